// File: hdl/dic_pkg.sv
package dic_pkg;
   // Register byte offsets (APB, 32-bit words)
   localparam logic [11:0] DIC_OFS_DLL_LOCK_STATUS   = 12'h000;
   localparam logic [11:0] DIC_OFS_INIT_CONTROL      = 12'h018;
   localparam logic [11:0] DIC_OFS_RESET_PIN_CONTROL = 12'h150;
   localparam logic [11:0] DIC_OFS_INIT_STATUS       = 12'h160;

   // dll_lock_status fields
   localparam int DIC_BIT_DLL_DONE       = 0;
   localparam int DIC_POS_DLL_COUNT      = 8;
   localparam int DIC_DLL_COUNT_W        = 8;
   // init_control fields
   localparam int DIC_BIT_INIT_START     = 0;
   localparam int DIC_BIT_DLL_BYPASS     = 1;
   localparam int DIC_BIT_CONFIGURING    = 2;
   // reset_pin_control fields
   localparam int DIC_POS_RESET_MODE     = 0;
   // init_status fields
   localparam int DIC_BIT_INIT_DONE      = 0;

   // Reset pin modes
   localparam logic [1:0] DIC_MODE_GENERAL = 2'h0;
   localparam logic [1:0] DIC_MODE_INHIBIT = 2'h1;
   localparam logic [1:0] DIC_MODE_REVERSE = 2'h2;

   // Reset values
   localparam logic [1:0] DIC_RST_RESET_MODE = 2'h0;
   localparam logic [7:0] DIC_RST_DLL_COUNT  = 8'h00;

   // Timing
   localparam int DIC_CLK_MHZ      = 250;
   localparam int DIC_DLL_TRY_NS   = 4000;
   localparam int DIC_DLL_TRY_CYC  = (DIC_DLL_TRY_NS * DIC_CLK_MHZ) / 1000;
   localparam int DIC_TMOD_CYC     = 12;
   localparam int DIC_TZQCL_CYC    = 512;
   localparam int DIC_TXPR_CYC     = 64;

   // DRAM commands {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] DIC_CMD_NOP  = 4'h7;
   localparam logic [3:0] DIC_CMD_MRS  = 4'h0;
   localparam logic [3:0] DIC_CMD_ZQCL = 4'h6;

   typedef struct packed {
      logic [3:0]  cmd;
      logic [1:0]  mr_sel;
      logic        valid;
   } dic_dram_cmd_s;

   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } dic_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } dic_apb_rsp_s;
endpackage

// File: hdl/dic_dll_model.sv
`timescale 1ns/1ps
module dic_dll_model
   import dic_pkg::*;
#(
   parameter int TRY_CYC = DIC_DLL_TRY_CYC
)(
   // Clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        clk_en,
   // Control
   input  wire logic                        start,
   input  wire logic                        lock_pin,
   // Result
   output logic                             locked,
   output logic                             timed_out,
   output logic [DIC_DLL_COUNT_W-1:0]       count
);
   import dic_pkg::*;

   logic [15:0] cyc;
   logic        busy;

   // Lock attempt: sweep delay until lock indication or timeout
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         busy      <= 1'b0;
         cyc       <= 16'h0000;
         locked    <= 1'b0;
         timed_out <= 1'b0;
         count     <= DIC_RST_DLL_COUNT;
      end
      else if (clk_en)
      begin
         if (start && !busy && !locked)
         begin
            busy      <= 1'b1;
            cyc       <= 16'h0000;
            timed_out <= 1'b0;
            count     <= DIC_RST_DLL_COUNT;
         end
         else if (busy)
         begin
            if (lock_pin)
            begin
               busy   <= 1'b0;
               locked <= 1'b1;
            end
            else if (cyc == 16'(TRY_CYC - 1))
            begin
               busy      <= 1'b0;
               timed_out <= 1'b1;
            end
            else
            begin
               cyc   <= cyc + 16'h0001;
               count <= count + 8'h01;
            end
         end
      end
endmodule

// File: hdl/dic_init_ctrl.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module dic_init_ctrl
   import dic_pkg::*;
#(
   parameter int DLL_TRY_CYC = DIC_DLL_TRY_CYC,
   parameter int TZQCL_CYC   = DIC_TZQCL_CYC
)(
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   // APB slave
   input  wire dic_pkg::dic_apb_req_s apb_req,
   output dic_pkg::dic_apb_rsp_s      apb_rsp,
   // PHY DLL
   input  wire logic                  dll_lock_pin,
   // DRAM side
   output dic_pkg::dic_dram_cmd_s     dram_cmd,
   output logic                       memory_reset_pin_n,
   // Memory access gate
   input  wire logic                  mem_req,
   output logic                       mem_grant,
   output logic                       mem_refused
);
   import dic_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DLL,
      ST_XPR,
      ST_MRS,
      ST_MRS_WAIT,
      ST_ZQCL,
      ST_DONE
   } dic_state_e;

   dic_state_e                 state;
   logic                       init_start;
   logic                       dll_bypass;
   logic                       configuring;
   logic [1:0]                 power_reset_pin_mode;
   logic                       init_done;
   logic                       pin_started;
   logic [15:0]                wait_cnt;
   logic [1:0]                 mr_idx;
   logic                       lock_s1;
   logic                       lock_s2;
   logic                       dll_locked;
   logic                       dll_timed_out;
   logic [DIC_DLL_COUNT_W-1:0] dll_lock_delay_count;
   logic                       wr_en;
   logic                       rd_en;
   logic [31:0]                next_prdata;
   logic                       addr_ok;
   logic                       next_pin;

   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite && clk_en;
   assign rd_en = apb_req.psel && apb_req.penable && !apb_req.pwrite && clk_en;

   // Lock pin synchroniser
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         lock_s1 <= 1'b0;
         lock_s2 <= 1'b0;
      end
      else if (clk_en)
      begin
         lock_s1 <= dll_lock_pin;
         lock_s2 <= lock_s1;
      end

   dic_dll_model #(
      .TRY_CYC   (DLL_TRY_CYC)
   ) u_dll (
      .pclk      (pclk),
      .presetn   (presetn),
      .clk_en    (clk_en),
      .start     (state == ST_DLL),
      .lock_pin  (lock_s2),
      .locked    (dll_locked),
      .timed_out (dll_timed_out),
      .count     (dll_lock_delay_count)
   );

   // Control registers
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         init_start           <= 1'b0;
         dll_bypass           <= 1'b0;
         configuring          <= 1'b0;
         power_reset_pin_mode <= DIC_RST_RESET_MODE;
      end
      else if (wr_en)
      begin
         case (apb_req.paddr)
            DIC_OFS_INIT_CONTROL:
            begin
               init_start  <= apb_req.pwdata[DIC_BIT_INIT_START];
               dll_bypass  <= apb_req.pwdata[DIC_BIT_DLL_BYPASS];
               configuring <= apb_req.pwdata[DIC_BIT_CONFIGURING];
            end
            DIC_OFS_RESET_PIN_CONTROL:
               power_reset_pin_mode <= apb_req.pwdata[DIC_POS_RESET_MODE +: 2];
            default:
               init_start <= init_start;
         endcase
      end

   // Init sequencer
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         state     <= ST_IDLE;
         wait_cnt  <= 16'h0000;
         mr_idx    <= 2'h0;
         init_done <= 1'b0;
         dram_cmd  <= '{cmd: DIC_CMD_NOP, mr_sel: 2'h0, valid: 1'b0};
      end
      else if (clk_en)
      begin
         dram_cmd <= '{cmd: DIC_CMD_NOP, mr_sel: 2'h0, valid: 1'b0};
         case (state)
            ST_IDLE:
               if (init_start)
                  state <= ST_DLL;
            ST_DLL:
               if (dll_locked || dll_bypass)
               begin
                  state    <= ST_XPR;
                  wait_cnt <= 16'h0000;
               end
            ST_XPR:
               if (wait_cnt == 16'(DIC_TXPR_CYC - 1))
               begin
                  state  <= ST_MRS;
                  mr_idx <= 2'h0;
               end
               else
                  wait_cnt <= wait_cnt + 16'h0001;
            ST_MRS:
            begin
               // MR2, MR3, MR1, MR0 order
               dram_cmd <= '{cmd: DIC_CMD_MRS,
                             mr_sel: 2'(mr_idx == 2'h0 ? 2'h2 : mr_idx == 2'h1 ? 2'h3 :
                                        mr_idx == 2'h2 ? 2'h1 : 2'h0),
                             valid: 1'b1};
               wait_cnt <= 16'h0000;
               state    <= ST_MRS_WAIT;
            end
            ST_MRS_WAIT:
               if (wait_cnt == 16'(DIC_TMOD_CYC - 1))
               begin
                  wait_cnt <= 16'h0000;
                  if (mr_idx == 2'h3)
                  begin
                     dram_cmd <= '{cmd: DIC_CMD_ZQCL, mr_sel: 2'h0, valid: 1'b1};
                     state    <= ST_ZQCL;
                  end
                  else
                  begin
                     mr_idx <= mr_idx + 2'h1;
                     state  <= ST_MRS;
                  end
               end
               else
                  wait_cnt <= wait_cnt + 16'h0001;
            ST_ZQCL:
               if (wait_cnt == 16'(TZQCL_CYC - 1))
               begin
                  state     <= ST_DONE;
                  init_done <= 1'b1;
               end
               else
                  wait_cnt <= wait_cnt + 16'h0001;
            ST_DONE:
               state <= ST_DONE;
            default:
               state <= ST_IDLE;
         endcase
      end

   // Reset pin behaviour
   always_comb
   begin
      next_pin = 1'b0;
      case (power_reset_pin_mode)
         DIC_MODE_GENERAL:
            next_pin = pin_started;
         DIC_MODE_REVERSE:
            next_pin = configuring && !pin_started;
         DIC_MODE_INHIBIT:
            next_pin = 1'b0;
         default:
            next_pin = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pin_started        <= 1'b0;
         memory_reset_pin_n <= 1'b0;
      end
      else if (clk_en)
      begin
         if (state != ST_IDLE)
            pin_started <= 1'b1;
         memory_reset_pin_n <= next_pin;
      end

   // Access gate
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         mem_grant   <= 1'b0;
         mem_refused <= 1'b0;
      end
      else if (clk_en)
      begin
         mem_grant   <= mem_req && init_done;
         mem_refused <= mem_req && !init_done;
      end

   // Read mux
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      addr_ok     = 1'b1;
      case (apb_req.paddr)
         DIC_OFS_DLL_LOCK_STATUS:
         begin
            next_prdata[DIC_BIT_DLL_DONE] = dll_locked;
            next_prdata[DIC_POS_DLL_COUNT +: DIC_DLL_COUNT_W] = dll_lock_delay_count;
         end
         DIC_OFS_INIT_CONTROL:
         begin
            next_prdata[DIC_BIT_INIT_START]  = init_start;
            next_prdata[DIC_BIT_DLL_BYPASS]  = dll_bypass;
            next_prdata[DIC_BIT_CONFIGURING] = configuring;
         end
         DIC_OFS_RESET_PIN_CONTROL:
            next_prdata[DIC_POS_RESET_MODE +: 2] = power_reset_pin_mode;
         DIC_OFS_INIT_STATUS:
            next_prdata[DIC_BIT_INIT_DONE] = init_done;
         default:
            addr_ok = 1'b0;
      endcase
   end

   // APB answer, registered from the setup phase, no wait states
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         apb_rsp <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
      else if (clk_en)
      begin
         apb_rsp.pready  <= apb_req.psel && !apb_req.penable;
         apb_rsp.pslverr <= apb_req.psel && !apb_req.penable && !addr_ok;
         if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
            apb_rsp.prdata <= next_prdata;
      end

   logic unused_rd;
   assign unused_rd = rd_en | dll_timed_out;
endmodule

// File: verification/dic_init_ctrl_checker.sv
`timescale 1ns/1ps
module dic_init_ctrl_checker
   import dic_pkg::*;
(
   // Clock, reset, APB
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   clk_en,
   input wire dic_pkg::dic_apb_req_s  apb_req,
   input wire dic_pkg::dic_apb_rsp_s  apb_rsp,
   // DRAM side and gate
   input wire logic                   dll_lock_pin,
   input wire dic_pkg::dic_dram_cmd_s dram_cmd,
   input wire logic                   memory_reset_pin_n,
   input wire logic                   mem_req,
   input wire logic                   mem_grant,
   input wire logic                   mem_refused
);
   logic [1:0] md;
   logic       st;
   logic       lk;
   logic       zq;
   logic [2:0] nmrs;
   logic       wr;
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadow of mode, start, lock and command history
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         md <= 2'h0;
         st <= 1'b0;
         lk <= 1'b0;
         zq <= 1'b0;
         nmrs <= 3'h0;
      end
      else
      begin
         if (wr && apb_req.paddr == DIC_OFS_RESET_PIN_CONTROL)
            md <= apb_req.pwdata[1:0];
         if (wr && apb_req.paddr == DIC_OFS_INIT_CONTROL && apb_req.pwdata[0])
            st <= 1'b1;
         if (dll_lock_pin || (wr && apb_req.paddr == DIC_OFS_INIT_CONTROL && apb_req.pwdata[1]))
            lk <= 1'b1;
         if (dram_cmd.valid && dram_cmd.cmd == DIC_CMD_ZQCL)
            zq <= 1'b1;
         if (dram_cmd.valid && dram_cmd.cmd == DIC_CMD_MRS)
            nmrs <= nmrs + 3'h1;
      end
   end
   AST_APB_READY: assert property (apb_req.psel && !apb_req.penable && clk_en |=> apb_rsp.pready)
      else $error("no ready after setup");
   AST_GEN_LOW: assert property ((md == 2'h0 && !st)[*2] |-> !memory_reset_pin_n)
      else $error("pin high before init");
   AST_GEN_HIGH: assert property ((md == 2'h0 && st)[*4] |-> memory_reset_pin_n)
      else $error("pin low after init");
   AST_REV_LOW: assert property ((md == 2'h2 && st)[*4] |-> !memory_reset_pin_n)
      else $error("reverse pin high after init");
   AST_INH_LOW: assert property ((md == 2'h1)[*3] |-> !memory_reset_pin_n)
      else $error("inhibit pin high");
   AST_CMD_LOCK: assert property (dram_cmd.valid |-> st && lk)
      else $error("command before start or lock");
   AST_ZQ_ORDER: assert property (dram_cmd.valid && dram_cmd.cmd == DIC_CMD_ZQCL |-> nmrs == 3'h4)
      else $error("calibration before mode sets");
   AST_GATE: assert property (mem_grant |-> zq && !mem_refused)
      else $error("grant before init");
endmodule
bind dic_init_ctrl dic_init_ctrl_checker chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .dll_lock_pin(dll_lock_pin), .dram_cmd(dram_cmd),
   .memory_reset_pin_n(memory_reset_pin_n), .mem_req(mem_req), .mem_grant(mem_grant),
   .mem_refused(mem_refused));

// File: verification/dic_dram_model.sv
`timescale 1ns/1ps
module dic_dram_model
   import dic_pkg::*;
#(
   parameter int LOCK_DLY = 20
)(
   // Clock and reset
   input wire logic                   pclk,
   input wire logic                   presetn,
   // PHY lock
   input wire logic                   lock_en,
   output logic                       dll_lock_pin,
   // Command bus record
   input wire dic_pkg::dic_dram_cmd_s dram_cmd,
   output logic [7:0]                 mr_seq,
   output logic [1:0]                 n_zq
);
   int cnt;
   // Lock after a delay when enabled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 0;
         dll_lock_pin <= 1'b0;
         mr_seq <= 8'h00;
         n_zq <= 2'h0;
      end
      else
      begin
         if (lock_en && cnt < LOCK_DLY)
            cnt <= cnt + 1;
         dll_lock_pin <= lock_en && cnt >= LOCK_DLY;
         if (dram_cmd.valid && dram_cmd.cmd == DIC_CMD_MRS)
            mr_seq <= {mr_seq[5:0], dram_cmd.mr_sel};
         if (dram_cmd.valid && dram_cmd.cmd == DIC_CMD_ZQCL)
            n_zq <= n_zq + 2'h1;
      end
   end
endmodule

// File: verification/dic_init_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin failures++; $display("Error %s expected %h seen %h", n, e, a); end end
module dic_init_ctrl_tb;
   import dic_pkg::*;
   logic          pclk, presetn, clk_en, lock_en, mem_req, lock_pin;
   logic          pin_n, grant, refused, err;
   dic_apb_req_s  req;
   dic_apb_rsp_s  rsp;
   dic_dram_cmd_s cmd;
   logic [7:0]    mr_seq;
   logic [1:0]    n_zq;
   logic [31:0]   rd;
   int            failures = 0;
   int            num_checks = 0;
   int            cyc = 0;
   dic_init_ctrl #(.DLL_TRY_CYC(8), .TZQCL_CYC(8)) uut (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .apb_req(req), .apb_rsp(rsp), .dll_lock_pin(lock_pin), .dram_cmd(cmd),
      .memory_reset_pin_n(pin_n), .mem_req(mem_req), .mem_grant(grant), .mem_refused(refused));
   dic_dram_model dram (.pclk(pclk), .presetn(presetn), .lock_en(lock_en),
      .dll_lock_pin(lock_pin), .dram_cmd(cmd), .mr_seq(mr_seq), .n_zq(n_zq));
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic rst();
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      // Wait for pready; the bench timeout ends this wait if it never rises
      do
      begin
         @(posedge pclk);
      end
      while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic poll(input logic pin);
      // Pin follows the start write three edges later
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 100; i++)
      begin
         apb(1'b0, DIC_OFS_INIT_STATUS, 32'h0000_0000);
         `CHK("reset_pin", pin, pin_n)
         if (rd[0] === 1'b1)
            break;
      end
      `CHK("init_done", 1'b1, rd[0])
   endtask
   task automatic t_regs();
      rst();
      apb(1'b0, DIC_OFS_DLL_LOCK_STATUS, 32'h0000_0000);
      `CHK("lock_status", 9'h000, {rd[15:8], rd[0]})
      apb(1'b0, DIC_OFS_RESET_PIN_CONTROL, 32'h0000_0000);
      `CHK("mode", DIC_RST_RESET_MODE, rd[1:0])
      apb(1'b0, 12'h004, 32'h0000_0000);
      `CHK("unmapped", 1'b1, err)
      // Clock enable low freezes the access gate
      clk_en  <= 1'b0;
      mem_req <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK("frozen", 1'b0, refused)
      clk_en <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK("refused_run", 1'b1, refused)
      mem_req <= 1'b0;
      $display("t_regs done");
   endtask
   task automatic t_general();
      rst();
      lock_en <= 1'b1;
      mem_req <= 1'b1;
      apb(1'b1, DIC_OFS_RESET_PIN_CONTROL, 32'h0000_0000);
      `CHK("pin_cfg", 1'b0, pin_n)
      `CHK("refused", 1'b1, refused)
      apb(1'b1, DIC_OFS_INIT_CONTROL, 32'h0000_0001);
      poll(1'b1);
      `CHK("mr_seq", 8'hb4, mr_seq)
      `CHK("zqcl", 2'h1, n_zq)
      apb(1'b0, DIC_OFS_DLL_LOCK_STATUS, 32'h0000_0000);
      `CHK("dll_done", 1'b1, rd[0])
      `CHK("dll_count", 1'b1, |rd[15:8])
      `CHK("grant", 1'b1, grant)
      mem_req <= 1'b0;
      lock_en <= 1'b0;
      $display("t_general done");
   endtask
   task automatic t_reverse();
      rst();
      apb(1'b1, DIC_OFS_RESET_PIN_CONTROL, {30'h0, DIC_MODE_REVERSE});
      apb(1'b1, DIC_OFS_INIT_CONTROL, 32'h0000_0004);
      repeat (2) @(posedge pclk);
      `CHK("pin_cfg", 1'b1, pin_n)
      apb(1'b1, DIC_OFS_INIT_CONTROL, 32'h0000_0005);
      repeat (200) @(posedge pclk);
      apb(1'b0, DIC_OFS_INIT_STATUS, 32'h0000_0000);
      `CHK("stalled", 1'b0, rd[0])
      `CHK("no_cmd", 8'h00, mr_seq)
      apb(1'b1, DIC_OFS_INIT_CONTROL, 32'h0000_0007);
      poll(1'b0);
      $display("t_reverse done");
   endtask
   task automatic t_inhibit();
      rst();
      lock_en <= 1'b1;
      apb(1'b1, DIC_OFS_RESET_PIN_CONTROL, {30'h0, DIC_MODE_INHIBIT});
      apb(1'b1, DIC_OFS_INIT_CONTROL, 32'h0000_0004);
      repeat (2) @(posedge pclk);
      `CHK("pin_cfg", 1'b0, pin_n)
      apb(1'b1, DIC_OFS_INIT_CONTROL, 32'h0000_0005);
      poll(1'b0);
      $display("t_inhibit done");
   endtask
   initial
   begin
      req = '0;
      presetn = 1'b0;
      clk_en = 1'b1;
      lock_en = 1'b0;
      mem_req = 1'b0;
      t_regs();
      t_general();
      t_reverse();
      t_inhibit();
      end_of_test();
   end
endmodule
